// ### hw/pom_panel.sv
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pom_regs.svh"

module pom_panel
  import pom_pkg::*;
#(
  parameter logic [47:0] OVR_CYCLES = 48'(`POM_OVR_CYCLES),
  parameter logic [32:0] BKL_CYCLES = 33'(`POM_BKL_CYCLES),
  // arbitrary value, not tied to any product
  parameter logic [15:0] RECOVERY_CODE = 16'h2580
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic key_up_i,
  input wire logic key_down_i,
  input wire logic key_enter_i,
  input wire logic key_hush_i,
  input wire logic [3:0] cmd_relay_i,
  input wire logic cmd_buzzer_i,
  input wire logic cmd_strobe_i,
  input wire logic cmd_horn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  output logic [3:0] relay_o,
  output logic buzzer_o,
  output logic strobe_o,
  output logic horn_o,
  output logic backlight_o,
  output logic hush_o,
  output logic [3:0] panel_addr_o
);

  pom_state_t s;
  pom_state_t next_s;

  logic [6:0] expire;
  logic k_hush;
  logic k_ent;
  logic k_up;
  logic k_dn;
  logic any_key;
  logic dig_ok;
  logic ent_fin;
  logic [15:0] ent_val;
  logic [2:0] ent_len;
  logic pwd_ok;
  logic bus_take;

  // one key per cycle; hush dominates so an escape is never lost
  assign k_hush = key_hush_i;
  assign k_ent = key_enter_i && !key_hush_i;
  assign k_up = key_up_i && !key_hush_i && !key_enter_i;
  assign k_dn = key_down_i && !key_hush_i && !key_enter_i && !key_up_i;
  assign any_key = key_up_i || key_down_i || key_enter_i || key_hush_i;

  // digit entry: value 10 is the end mark, so shorter codes can be closed
  assign dig_ok = s.digit != `POM_DIGIT_END;
  assign ent_fin = k_ent && (!dig_ok || s.ecnt == 3'h3);
  assign ent_val = dig_ok ? {s.ent[11:0], s.digit} : s.ent;
  assign ent_len = dig_ok ? s.ecnt + 3'h1 : s.ecnt;
  assign pwd_ok = (ent_len == s.pw_len) && (ent_val == s.pw);

  assign bus_take = hsel_i && hready_i && htrans_i[1];

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_tmr
      pom_ovr_timer #(.LIMIT(OVR_CYCLES)) u_tmr (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .active_i(s.ovr[gi]),
        .expire_o(expire[gi])
      );
    end
  endgenerate

  function automatic logic [2:0] item_last(input logic [1:0] br);
    case (br)
      2'h0: item_last = 3'h2;
      2'h1: item_last = 3'h3;
      default: item_last = 3'h6;
    endcase
  endfunction

  function automatic pom_state_t clr_entry(input pom_state_t x);
    pom_state_t y;
    y = x;
    y.digit = 4'h0;
    y.ent = 16'h0;
    y.ecnt = 3'h0;
    return y;
  endfunction

  always_comb begin
    logic [6:0] ovr_set;
    logic [6:0] ovr_clr;
    logic clr_all;
    logic [6:0] silence;
    logic [31:0] rd;
    ovr_set = 7'h0;
    ovr_clr = 7'h0;
    clr_all = 1'b0;
    silence = 7'h0;
    rd = 32'h0;
    next_s = s;

    case (s.mode)
      POM_MONITOR: begin
        if (k_hush) begin
          next_s.hush = !s.hush;
        end else if (k_ent) begin
          next_s.mode = POM_TOP;
          next_s.cur = 2'h0;
        end
      end
      POM_TOP: begin
        if (k_hush) begin
          next_s.mode = POM_MONITOR;
        end else if (k_up) begin
          next_s.cur = (s.cur == 2'h2) ? 2'h0 : s.cur + 2'h1;
        end else if (k_dn) begin
          next_s.cur = (s.cur == 2'h0) ? 2'h2 : s.cur - 2'h1;
        end else if (k_ent) begin
          case (s.cur)
            2'h0: next_s = clr_entry(s);
            2'h1: clr_all = 1'b1;
            default: next_s = clr_entry(s);
          endcase
          next_s.mode = (s.cur == 2'h0) ? POM_PWD : (s.cur == 2'h1) ? POM_MONITOR : POM_RCODE;
        end
      end
      POM_PWD, POM_NEWPWD, POM_RCODE: begin
        if (k_hush) begin
          next_s.mode = (s.mode == POM_NEWPWD) ? POM_SUB : POM_TOP;
        end else if (k_up) begin
          next_s.digit = (s.digit == `POM_DIGIT_END) ? 4'h0 : s.digit + 4'h1;
        end else if (k_dn) begin
          next_s.digit = (s.digit == 4'h0) ? `POM_DIGIT_END : s.digit - 4'h1;
        end else if (ent_fin) begin
          next_s = clr_entry(s);
          if (s.mode == POM_PWD) begin
            next_s.mode = pwd_ok ? POM_MAIN : POM_MONITOR;
            next_s.cur = 2'h0;
          end else if (s.mode == POM_NEWPWD) begin
            next_s.mode = POM_SUB;
            if (ent_len != 3'h0) begin
              next_s.pw = ent_val;
              next_s.pw_len = ent_len;
            end
          end else begin
            next_s.mode = POM_TOP;
            if (ent_len == 3'h4 && ent_val == RECOVERY_CODE) begin
              next_s.pw = `POM_PW_DEFAULT;
              next_s.pw_len = `POM_PW_LEN_DEFAULT;
            end
          end
        end else if (k_ent) begin
          next_s.ent = ent_val;
          next_s.ecnt = ent_len;
          next_s.digit = 4'h0;
        end
      end
      POM_MAIN: begin
        if (k_hush) begin
          next_s.mode = POM_TOP;
        end else if (k_up) begin
          next_s.cur = (s.cur == 2'h2) ? 2'h0 : s.cur + 2'h1;
        end else if (k_dn) begin
          next_s.cur = (s.cur == 2'h0) ? 2'h2 : s.cur - 2'h1;
        end else if (k_ent) begin
          next_s.mode = POM_SUB;
          next_s.item = 3'h0;
        end
      end
      POM_SUB: begin
        if (k_hush) begin
          next_s.mode = POM_MAIN;
        end else if (k_up) begin
          next_s.item = (s.item == item_last(s.cur)) ? 3'h0 : s.item + 3'h1;
        end else if (k_dn) begin
          next_s.item = (s.item == 3'h0) ? item_last(s.cur) : s.item - 3'h1;
        end else if (k_ent) begin
          if (s.cur == 2'h0) begin
            if (s.item == 3'h0) begin
              next_s.addr = (s.addr == `POM_ADDR_MAX) ? 4'h0 : s.addr + 4'h1;
            end else if (s.item == 3'h1) begin
              next_s.bkl = (s.bkl == POM_BKL_OFF) ? POM_BKL_AUTO : pom_bkl_t'(s.bkl + 2'h1);
            end else begin
              next_s = clr_entry(s);
              next_s.mode = POM_NEWPWD;
            end
          end else if (s.cur == 2'h1) begin
            next_s.style[s.item[1:0]] = !s.style[s.item[1:0]];
          end else if (s.ovr[s.item]) begin
            ovr_clr[s.item] = 1'b1;
          end else begin
            ovr_set[s.item] = 1'b1;
          end
        end
      end
      default: next_s.mode = POM_MONITOR;
    endcase

    // bus write lands in its data phase
    if (s.aw) begin
      case (s.aaddr)
        `POM_REG_CTRL: clr_all = clr_all || hwdata_i[`POM_CTRL_CLR_BIT];
        `POM_REG_SETTINGS: begin
          if (hwdata_i[`POM_SET_ADDR_LSB +: 4] <= `POM_ADDR_MAX) begin
            next_s.addr = hwdata_i[`POM_SET_ADDR_LSB +: 4];
          end
          if (hwdata_i[`POM_SET_BKL_LSB +: 2] != 2'h3) begin
            next_s.bkl = pom_bkl_t'(hwdata_i[`POM_SET_BKL_LSB +: 2]);
          end
          next_s.style = hwdata_i[`POM_SET_STYLE_LSB +: 4];
        end
        `POM_REG_OVERRIDE: begin
          ovr_set = ovr_set | (hwdata_i[6:0] & ~s.ovr);
          ovr_clr = ovr_clr | (~hwdata_i[6:0] & s.ovr);
        end
        `POM_REG_PASSWORD: begin
          if (hwdata_i[`POM_PW_LEN_LSB +: 3] != 3'h0 && hwdata_i[`POM_PW_LEN_LSB +: 3] <= `POM_PW_LEN_MAX) begin
            next_s.pw = hwdata_i[15:0];
            next_s.pw_len = hwdata_i[`POM_PW_LEN_LSB +: 3];
          end
        end
        `POM_REG_RECOVER: begin
          if (hwdata_i[15:0] == RECOVERY_CODE) begin
            next_s.pw = `POM_PW_DEFAULT;
            next_s.pw_len = `POM_PW_LEN_DEFAULT;
          end
        end
        default: ;
      endcase
    end

    // an entry into override wins over a clear in the same cycle
    next_s.ovr = (s.ovr & ~expire & ~ovr_clr & ~{7{clr_all}}) | ovr_set;

    silence = s.hush ? {1'b1, 1'b0, 1'b1, s.style} : 7'h0;
    next_s.outv = s.ovr | ({cmd_horn_i, cmd_strobe_i, cmd_buzzer_i, cmd_relay_i} & ~silence);

    if (any_key) begin
      next_s.bl_cnt = BKL_CYCLES - 33'h1;
    end else if (s.bl_cnt != 33'h0) begin
      next_s.bl_cnt = s.bl_cnt - 33'h1;
    end
    case (s.bkl)
      POM_BKL_ON: next_s.bl_on = 1'b1;
      POM_BKL_OFF: next_s.bl_on = 1'b0;
      default: next_s.bl_on = any_key || (s.bl_cnt != 33'h0);
    endcase

    // read data is fetched in the address phase so it stands from a flop
    case (haddr_i[7:0])
      `POM_REG_SETTINGS: rd = {20'h0, s.style, 2'h0, s.bkl, s.addr};
      `POM_REG_OVERRIDE: rd = {25'h0, s.ovr};
      `POM_REG_PASSWORD: rd = {13'h0, s.pw_len, s.pw};
      `POM_REG_STATUS: rd = {19'h0, s.bl_on, s.hush, s.outv, s.mode};
      default: rd = 32'h0;
    endcase
    next_s.aw = bus_take && hwrite_i;
    next_s.aaddr = haddr_i[7:0];
    next_s.rdata = (bus_take && !hwrite_i) ? rd : 32'h0;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      s <= '0;
      s.mode <= POM_MONITOR;
      s.pw <= `POM_PW_DEFAULT;
      s.pw_len <= `POM_PW_LEN_DEFAULT;
      s.addr <= `POM_ADDR_DEFAULT;
      s.bkl <= POM_BKL_AUTO;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = s.rdata;
  assign relay_o = s.outv[3:0];
  assign buzzer_o = s.outv[4];
  assign strobe_o = s.outv[5];
  assign horn_o = s.outv[6];
  assign backlight_o = s.bl_on;
  assign hush_o = s.hush;
  assign panel_addr_o = s.addr;

  property p_hush_on;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (s.mode == POM_MONITOR && !s.hush && k_hush) |=> s.hush ##1 (!horn_o || $past(s.ovr[6])) && (!buzzer_o || $past(s.ovr[4]));
  endproperty
  a_hush_on: assert property (p_hush_on) else $error("hush did not silence buzzer and horn");

  property p_hush_off;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (s.mode == POM_MONITOR && s.hush && k_hush) |=> !s.hush;
  endproperty
  a_hush_off: assert property (p_hush_off) else $error("second hush press did not cancel");

  property p_menu_entry;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (s.mode == POM_MONITOR && k_ent) |=> (s.mode == POM_TOP);
  endproperty
  a_menu_entry: assert property (p_menu_entry) else $error("enter did not open the menu");

  property p_pwd_gate;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (s.mode == POM_PWD && ent_fin) |=> (s.mode == (($past(pwd_ok)) ? POM_MAIN : POM_MONITOR));
  endproperty
  a_pwd_gate: assert property (p_pwd_gate) else $error("password gate admitted wrongly");

  property p_pw_default;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    !$past(reset_n_i) |-> (s.pw == `POM_PW_DEFAULT && s.pw_len == `POM_PW_LEN_DEFAULT && s.addr == `POM_ADDR_DEFAULT);
  endproperty
  a_pw_default: assert property (p_pw_default) else $error("reset values wrong");

  property p_clear_all;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (s.mode == POM_TOP && s.cur == 2'h1 && k_ent && !s.aw) |=> (s.ovr == 7'h0) ##1 (s.outv == $past({cmd_horn_i, cmd_strobe_i, cmd_buzzer_i, cmd_relay_i} & ~(s.hush ? {1'b1, 1'b0, 1'b1, s.style} : 7'h0)));
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear override left an output forced");

  property p_expire;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (|expire) && !s.aw && s.mode != POM_SUB |=> ((s.ovr & $past(expire)) == 7'h0);
  endproperty
  a_expire: assert property (p_expire) else $error("override survived its time-out");

  property p_ovr_hold;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    1'b1 |=> ((s.outv & $past(s.ovr)) == $past(s.ovr));
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("overridden output not actuated");

  property p_addr_range;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    s.addr <= `POM_ADDR_MAX;
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("panel address out of range");

  property p_bkl_auto;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (s.bkl == POM_BKL_AUTO && any_key && !s.aw) |=> backlight_o ##1 (backlight_o || s.bkl != POM_BKL_AUTO);
  endproperty
  a_bkl_auto: assert property (p_bkl_auto) else $error("key press did not light backlight");

  property p_style_hush;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    1'b1 |=> ((relay_o & $past(s.style) & ~$past(s.ovr[3:0]) & {4{$past(s.hush)}}) == 4'h0);
  endproperty
  a_style_hush: assert property (p_style_hush) else $error("buzzer-style relay on under hush");

endmodule

`default_nettype wire

// ### hw/pom_regs.svh
`ifndef POM_REGS_SVH
`define POM_REGS_SVH

// register byte offsets on the bus
`define POM_REG_CTRL 8'h00
`define POM_REG_SETTINGS 8'h04
`define POM_REG_OVERRIDE 8'h08
`define POM_REG_PASSWORD 8'h0c
`define POM_REG_STATUS 8'h10
`define POM_REG_RECOVER 8'h14

// field positions
`define POM_CTRL_CLR_BIT 0
`define POM_SET_ADDR_LSB 0
`define POM_SET_BKL_LSB 4
`define POM_SET_STYLE_LSB 8
`define POM_PW_LEN_LSB 16
`define POM_ST_OUT_LSB 4
`define POM_ST_HUSH_BIT 11
`define POM_ST_BKL_BIT 12

// reset values and limits
`define POM_PW_DEFAULT 16'h4321
`define POM_PW_LEN_DEFAULT 3'h4
`define POM_PW_LEN_MAX 3'h4
`define POM_ADDR_DEFAULT 4'h3
`define POM_ADDR_MAX 4'hb
`define POM_DIGIT_MAX 4'h9
`define POM_DIGIT_END 4'ha

// timing
`define POM_CLK_HZ 64'd250000000
`define POM_OVR_TIME_MIN 64'd720
`define POM_BKL_TIME_S 64'd30
`define POM_OVR_CYCLES (`POM_OVR_TIME_MIN * 64'd60 * `POM_CLK_HZ)
`define POM_BKL_CYCLES (`POM_BKL_TIME_S * `POM_CLK_HZ)

`endif

// ### hw/pom_pkg.sv
package pom_pkg;

  // gray along monitor -> top -> password -> main -> sub -> new password
  typedef enum logic [3:0] {
    POM_MONITOR = 4'h0,
    POM_TOP = 4'h1,
    POM_PWD = 4'h3,
    POM_MAIN = 4'h2,
    POM_SUB = 4'h6,
    POM_NEWPWD = 4'h7,
    POM_RCODE = 4'h5
  } pom_mode_t;

  typedef enum logic [1:0] {
    POM_BKL_AUTO = 2'h0,
    POM_BKL_ON = 2'h1,
    POM_BKL_OFF = 2'h2
  } pom_bkl_t;

  typedef struct packed {
    logic [47:0] cnt;
  } pom_tmr_state_t;

  typedef struct packed {
    pom_mode_t mode;
    logic [1:0] cur;
    logic [2:0] item;
    logic [3:0] digit;
    logic [15:0] ent;
    logic [2:0] ecnt;
    logic [15:0] pw;
    logic [2:0] pw_len;
    logic [3:0] addr;
    pom_bkl_t bkl;
    logic [3:0] style;
    logic [6:0] ovr;
    logic hush;
    logic [6:0] outv;
    logic [32:0] bl_cnt;
    logic bl_on;
    logic aw;
    logic [7:0] aaddr;
    logic [31:0] rdata;
  } pom_state_t;

endpackage

// ### hw/pom_ovr_timer.sv
`timescale 1ns/1ps
`default_nettype none

module pom_ovr_timer
  import pom_pkg::*;
#(
  parameter logic [47:0] LIMIT = 48'h1
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic active_i,
  output logic expire_o
);

  pom_tmr_state_t s;
  pom_tmr_state_t next_s;

  // counter only runs while the output is overridden, restarts from zero each time
  always_comb begin
    next_s = s;
    if (!active_i || expire_o) begin
      next_s.cnt = 48'h0;
    end else begin
      next_s.cnt = s.cnt + 48'h1;
    end
  end

  assign expire_o = active_i && (s.cnt == LIMIT - 48'h1);

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  property p_tmr_bound;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    active_i |-> (s.cnt < LIMIT);
  endproperty
  a_tmr_bound: assert property (p_tmr_bound) else $error("override timer ran past its limit");

  property p_tmr_idle_clear;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    !active_i |=> (s.cnt == 48'h0);
  endproperty
  a_tmr_idle_clear: assert property (p_tmr_idle_clear) else $error("timer not cleared after override end");

endmodule

`default_nettype wire

// ### test/pom_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module pom_ctrl_model (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [6:0] pattern_i,
  output logic [3:0] cmd_relay_o,
  output logic cmd_buzzer_o,
  output logic cmd_strobe_o,
  output logic cmd_horn_o
);
  // commands land a cycle late, as a frame decoded off the serial link would
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      {cmd_horn_o, cmd_strobe_o, cmd_buzzer_o, cmd_relay_o} <= 7'h00;
    end else begin
      {cmd_horn_o, cmd_strobe_o, cmd_buzzer_o, cmd_relay_o} <= pattern_i;
    end
  end
endmodule

`default_nettype wire

// ### test/pom_panel_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pom_regs.svh"

module pom_panel_bench;
  localparam logic [47:0] OVR = 48'd50;
  localparam logic [32:0] BKL = 33'd20;
  localparam logic [15:0] RCODE = 16'h2580;
  localparam logic [3:0] K_H = 4'h8;
  localparam logic [3:0] K_E = 4'h4;
  localparam logic [3:0] K_U = 4'h2;
  localparam logic [3:0] K_D = 4'h1;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [3:0] keys = 4'h0;
  logic [6:0] pattern = 7'h00;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] cmd_relay;
  logic cmd_buzzer;
  logic cmd_strobe;
  logic cmd_horn;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [3:0] relay;
  logic buzzer;
  logic strobe;
  logic horn;
  logic backlight;
  logic hush;
  logic [3:0] panel_addr;
  int bad_count = 0;
  int checks = 0;
  wire [6:0] outs = {horn, strobe, buzzer, relay};

  always #2 ref_clk_i = ~ref_clk_i;

  pom_ctrl_model u_pom_ctrl_model (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .pattern_i(pattern),
    .cmd_relay_o(cmd_relay), .cmd_buzzer_o(cmd_buzzer), .cmd_strobe_o(cmd_strobe), .cmd_horn_o(cmd_horn));

  pom_panel #(.OVR_CYCLES(OVR), .BKL_CYCLES(BKL), .RECOVERY_CODE(RCODE)) u_pom_panel (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .key_up_i(keys[1]), .key_down_i(keys[0]),
    .key_enter_i(keys[2]), .key_hush_i(keys[3]), .cmd_relay_i(cmd_relay), .cmd_buzzer_i(cmd_buzzer),
    .cmd_strobe_i(cmd_strobe), .cmd_horn_i(cmd_horn), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout), .hreadyout_o(hreadyout),
    .hresp_o(hresp), .hrdata_o(hrdata), .relay_o(relay), .buzzer_o(buzzer), .strobe_o(strobe), .horn_o(horn),
    .backlight_o(backlight), .hush_o(hush), .panel_addr_o(panel_addr));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task stop_test;
    if (bad_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge ref_clk_i);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge ref_clk_i);
    while (hreadyout !== 1'b1) @(posedge ref_clk_i);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge ref_clk_i);
    while (hreadyout !== 1'b1) @(posedge ref_clk_i);
    rd = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, exp);
  endtask

  task mode_chk(input logic [3:0] exp);
    logic [31:0] x;
    bus(1'b0, `POM_REG_STATUS, 32'h0, x);
    chk({28'h0, x[3:0]}, {28'h0, exp});
  endtask

  task cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task press(input logic [3:0] k);
    @(posedge ref_clk_i);
    keys <= k;
    @(posedge ref_clk_i);
    keys <= 4'h0;
  endtask

  // digit starts at 0 and is raised with up, most significant first
  task digits(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      repeat (int'(v[i*4 +: 4])) press(K_U);
      press(K_E);
    end
  endtask

  task t_reset;
    chk({28'h0, panel_addr}, 32'h3);
    chk({25'h0, outs}, 32'h0);
    chk({30'h0, hresp, hreadyout}, 32'h1);
    rdchk(`POM_REG_SETTINGS, 32'h3);
    rdchk(`POM_REG_PASSWORD, 32'h0004_4321);
  endtask

  task t_hush;
    pattern <= 7'h7f;
    wr(`POM_REG_SETTINGS, 32'h103);
    cyc(3);
    chk({25'h0, outs}, 32'h7f);
    press(K_H);
    cyc(3);
    chk({31'h0, hush}, 32'h1);
    chk({25'h0, outs}, 32'h2e);
    press(K_H);
    cyc(3);
    chk({25'h0, outs}, 32'h7f);
    pattern <= 7'h00;
  endtask

  task t_menu;
    logic [31:0] x;
    press(K_E);
    mode_chk(4'h1);
    press(K_E);
    mode_chk(4'h3);
    digits(16'h1111, 4);
    bus(1'b0, `POM_REG_STATUS, 32'h0, x);
    chk({31'h0, x[3:0] == 4'h2}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, `POM_REG_STATUS, 32'h0, x);
      if (x[3:0] != 4'h0) press(K_H);
    end
    press(K_E);
    press(K_E);
    digits(16'h4321, 4);
    mode_chk(4'h2);
    press(K_U);
    press(K_U);
    press(K_E);
    mode_chk(4'h6);
    press(K_E);
    press(K_U);
    press(K_E);
    cyc(3);
    chk({25'h0, outs}, 32'h03);
    press(K_E);
    cyc(3);
    chk({25'h0, outs}, 32'h01);
    cyc(int'(OVR) + 5);
    chk({25'h0, outs}, 32'h00);
    press(K_H);
    mode_chk(4'h2);
    press(K_H);
    mode_chk(4'h1);
    press(K_H);
    mode_chk(4'h0);
  endtask

  task t_bus_ovr;
    press(K_H);
    wr(`POM_REG_OVERRIDE, 32'h7f);
    cyc(2);
    chk({25'h0, outs}, 32'h7f);
    rdchk(`POM_REG_OVERRIDE, 32'h7f);
    wr(`POM_REG_CTRL, 32'h1);
    cyc(2);
    chk({25'h0, outs}, 32'h00);
    press(K_H);
    wr(`POM_REG_OVERRIDE, 32'h7f);
    press(K_E);
    press(K_U);
    press(K_E);
    cyc(2);
    chk({25'h0, outs}, 32'h00);
    mode_chk(4'h0);
  endtask

  // second output enters override halfway through the first one's time-out
  task t_timers;
    wr(`POM_REG_OVERRIDE, 32'h1);
    cyc(25);
    wr(`POM_REG_OVERRIDE, 32'h3);
    cyc(25);
    rdchk(`POM_REG_OVERRIDE, 32'h2);
    wr(`POM_REG_OVERRIDE, 32'h0);
    cyc(2);
    chk({25'h0, outs}, 32'h00);
  endtask

  task t_settings;
    wr(`POM_REG_SETTINGS, 32'h0b);
    cyc(1);
    chk({28'h0, panel_addr}, 32'hb);
    wr(`POM_REG_SETTINGS, 32'h0c);
    cyc(1);
    chk({28'h0, panel_addr}, 32'hb);
    wr(`POM_REG_SETTINGS, 32'h1b);
    cyc(2);
    chk({31'h0, backlight}, 32'h1);
    wr(`POM_REG_SETTINGS, 32'h2b);
    wr(`POM_REG_SETTINGS, 32'h3b);
    cyc(2);
    chk({31'h0, backlight}, 32'h0);
    rdchk(`POM_REG_SETTINGS, 32'h2b);
    wr(`POM_REG_SETTINGS, 32'h0b);
    cyc(int'(BKL) + 5);
    chk({31'h0, backlight}, 32'h0);
    press(K_U);
    cyc(2);
    chk({31'h0, backlight}, 32'h1);
    cyc(int'(BKL) + 2);
    chk({31'h0, backlight}, 32'h0);
  endtask

  task t_password;
    wr(`POM_REG_PASSWORD, 32'h0002_0042);
    rdchk(`POM_REG_PASSWORD, 32'h0002_0042);
    wr(`POM_REG_PASSWORD, 32'h0000_0099);
    wr(`POM_REG_PASSWORD, 32'h0005_1234);
    rdchk(`POM_REG_PASSWORD, 32'h0002_0042);
    press(K_E);
    press(K_E);
    digits(16'h0042, 2);
    press(K_D);
    press(K_E);
    mode_chk(4'h2);
    press(K_H);
    press(K_H);
    wr(`POM_REG_RECOVER, 32'h1111);
    rdchk(`POM_REG_PASSWORD, 32'h0002_0042);
    wr(`POM_REG_RECOVER, {16'h0, RCODE});
    rdchk(`POM_REG_PASSWORD, 32'h0004_4321);
  endtask

  // keypad paths: new password entry, then recovery code from the top menu
  task t_keypad_pw;
    press(K_E);
    press(K_E);
    digits(16'h4321, 4);
    press(K_E);
    press(K_U);
    press(K_U);
    press(K_E);
    mode_chk(4'h7);
    digits(16'h0007, 1);
    press(K_D);
    press(K_E);
    rdchk(`POM_REG_PASSWORD, 32'h0001_0007);
    mode_chk(4'h6);
    press(K_H);
    press(K_H);
    press(K_D);
    press(K_E);
    mode_chk(4'h5);
    digits(RCODE, 4);
    rdchk(`POM_REG_PASSWORD, 32'h0004_4321);
    mode_chk(4'h1);
    press(K_H);
    mode_chk(4'h0);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    bad_count++;
    stop_test;
  end

  initial begin
    repeat (10) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    t_reset;
    t_hush;
    t_menu;
    t_bus_ovr;
    t_timers;
    t_settings;
    t_password;
    t_keypad_pw;
    stop_test;
  end
endmodule

`default_nettype wire
